// >>> src/ims_consts.vh
// constants of the i2c master sequencer
// How it works
// - after reset the block is slave; only a start makes it master
// - start request with peripheral enabled and bus idle sets master flag and drives a start
// - after start, event and start-sent flags set; interrupt if enabled
// - scl held low until status read then address write to data reg
// - address shifted out msb first; 7-bit mode sends one byte
// - 10-bit: after header, event set, scl held until read+write
// - after address (and ack), event set; held until read+control write
// - received byte shifted into shift reg, then ack if enabled, then pushed to the fifo
// - after byte and ack slot, event and byte-finished flags set
// - scl held low until status read then data register read
// - after stop the master flag clears and the block is slave again
// - stop set then cleared while byte-finished frees the lines
`ifndef IMS_CONSTS_VH
`define IMS_CONSTS_VH
`define IMS_CLK_MHZ      25
`define IMS_TLOW_NS      4700
`define IMS_QTR_CYCLES   ((`IMS_TLOW_NS*`IMS_CLK_MHZ+1999)/2000)
`define IMS_QW           8
`define IMS_LAST_BIT     4'h7
`define IMS_ACK_BIT      4'h8
`define IMS_HDR_TAG      5'h1E
`define IMS_FIFO_DEPTH   8
`define IMS_S_IDLE       4'h0
`define IMS_S_START      4'h1
`define IMS_S_WADDR      4'h2
`define IMS_S_TX         4'h3
`define IMS_S_WHDR       4'h4
`define IMS_S_WCTL       4'h5
`define IMS_S_RX         4'h6
`define IMS_S_PUSH       4'h7
`define IMS_S_WRX        4'h8
`define IMS_S_STOP       4'h9
`endif

// >>> src/ims_fifo.v
// small fifo holding received bytes
`timescale 1ns/10ps
module ims_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,
    input  wire             rst_b,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;
    wire [AW-1:0]   next_rptr;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;
    assign next_rptr = do_rd ? rptr + 1'b1 : rptr;

    // storage write
    always @(posedge mclk) begin
        if (do_wr) begin
            mem[wptr] <= in_data;
        end
    end

    // pointers, fill level and registered head word
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wptr     <= {AW{1'b0}};
            rptr     <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                wptr <= wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= rptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
            // head word always shown; a write into an empty fifo bypasses
            if (do_wr && (wptr == next_rptr)) begin
                out_data <= in_data;
            end else begin
                out_data <= mem[next_rptr];
            end
        end
    end
endmodule // ims_fifo

// >>> src/ims_master.v
// i2c master sequencer: start, address, receive, stop
`timescale 1ns/10ps
`include "ims_consts.vh"
module ims_master #(
    parameter QTR = `IMS_QTR_CYCLES
) (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire       peripheral_enable,
    input  wire       start_req,
    input  wire       stop_req,
    input  wire       ack_en,
    input  wire       addr_10bit,
    input  wire       event_interrupt_enable,
    input  wire       status_read,
    input  wire       data_write,
    input  wire [7:0] data_wdata,
    input  wire       data_read,
    input  wire       control_write,
    output reg  [7:0] data_reg,
    output wire       data_valid,
    output reg        master_select_flag,
    output reg        event_flag,
    output reg        start_sent_flag,
    output reg        byte_transfer_finished,
    output reg        bus_busy,
    output reg        slave_nack,
    output reg        event_irq,
    input  wire       scl_in,
    output wire       scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe
);
    reg  [3:0]          state;
    reg  [1:0]          phase;
    reg  [3:0]          bitn;
    reg  [7:0]          shift;
    reg  [7:0]          addr_byte;
    reg                 hdr_sent;
    reg                 status_seen;
    reg                 stop_pend;
    reg  [`IMS_QW-1:0]  qcnt;
    reg                 scl_prev;
    reg                 sda_prev;
    reg                 push_valid;
    wire                tick;
    wire                push_ready;
    wire                fifo_pop;
    wire [7:0]          fifo_head;

    // open-drain pins only ever pull low
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign tick     = (qcnt == QTR[`IMS_QW-1:0] - 1'b1);
    assign fifo_pop = data_read && status_seen && (state == `IMS_S_WRX);

    // true when a byte carries the 10-bit header tag
    function is_header;
        input [7:0] b;
        begin
            is_header = (b[7:3] == `IMS_HDR_TAG);
        end
    endfunction

    ims_fifo #(
        .WIDTH (8),
        .DEPTH (`IMS_FIFO_DEPTH),
        .AW    (3)
    ) ims_fifo_i (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (shift),
        .out_valid (data_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_head)
    );

    // quarter-bit enable divider
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            qcnt <= {`IMS_QW{1'b0}};
        end else if (tick || state == `IMS_S_IDLE) begin
            qcnt <= {`IMS_QW{1'b0}};
        end else begin
            qcnt <= qcnt + 1'b1;
        end
    end

    // bus busy from start/stop seen on the lines
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            bus_busy <= 1'b0;
        end else begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
            if (scl_in && scl_prev && sda_prev && !sda_in) begin
                bus_busy <= 1'b1;
            end else if (scl_in && scl_prev && !sda_prev && sda_in) begin
                bus_busy <= 1'b0;
            end
        end
    end

    // registered event interrupt
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= event_flag && event_interrupt_enable;
        end
    end

    // data register takes the written address byte in the address waits, else mirrors the fifo head
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_reg <= 8'h00;
        end else if (state == `IMS_S_WADDR || state == `IMS_S_WHDR) begin
            if (data_write && status_seen) begin
                data_reg <= data_wdata;
            end
        end else begin
            data_reg <= fifo_head;
        end
    end

    // main sequencer
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state                  <= `IMS_S_IDLE;
            phase                  <= 2'h0;
            bitn                   <= 4'h0;
            shift                  <= 8'h00;
            addr_byte              <= 8'h00;
            hdr_sent               <= 1'b0;
            status_seen            <= 1'b0;
            stop_pend              <= 1'b0;
            push_valid             <= 1'b0;
            master_select_flag     <= 1'b0;
            event_flag             <= 1'b0;
            start_sent_flag        <= 1'b0;
            byte_transfer_finished <= 1'b0;
            slave_nack             <= 1'b0;
            scl_oe                 <= 1'b0;
            sda_oe                 <= 1'b0;
        end else begin
            // first half of each clearing sequence
            if (status_read && event_flag) begin
                status_seen <= 1'b1;
            end
            // stop pulse while byte finished is remembered
            if (stop_req && byte_transfer_finished) begin
                stop_pend <= 1'b1;
            end
            case (state)
            `IMS_S_IDLE: begin
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                phase  <= 2'h0;
                if (peripheral_enable && start_req && !bus_busy) begin
                    master_select_flag <= 1'b1;
                    state              <= `IMS_S_START;
                end
            end
            `IMS_S_START: if (tick) begin
                phase <= phase + 1'b1;
                case (phase)
                2'h0: begin
                    sda_oe <= 1'b0;
                    scl_oe <= 1'b0;
                end
                2'h1: begin
                    if (scl_in) begin
                        sda_oe <= 1'b1;
                    end else begin
                        phase <= phase;
                    end
                end
                2'h2: scl_oe <= 1'b1;
                default: begin
                    event_flag      <= 1'b1;
                    start_sent_flag <= 1'b1;
                    status_seen     <= 1'b0;
                    hdr_sent        <= 1'b0;
                    state           <= `IMS_S_WADDR;
                end
                endcase
            end
            `IMS_S_WADDR, `IMS_S_WHDR: begin
                scl_oe <= 1'b1;
                if (data_write && status_seen) begin
                    shift           <= data_wdata;
                    event_flag      <= 1'b0;
                    start_sent_flag <= 1'b0;
                    status_seen     <= 1'b0;
                    bitn            <= 4'h0;
                    phase           <= 2'h0;
                    if (state == `IMS_S_WADDR) begin
                        addr_byte <= data_wdata;
                    end
                    state <= `IMS_S_TX;
                end
            end
            `IMS_S_TX, `IMS_S_RX: if (tick) begin
                phase <= phase + 1'b1;
                case (phase)
                2'h0: begin
                    if (state == `IMS_S_TX) begin
                        sda_oe <= (bitn != `IMS_ACK_BIT) && !shift[7];
                    end else begin
                        sda_oe <= (bitn == `IMS_ACK_BIT) && ack_en;
                    end
                end
                2'h1: begin
                    if (scl_oe) begin
                        scl_oe <= 1'b0;
                        phase  <= phase;
                    end else if (!scl_in) begin
                        phase <= phase;
                    end
                end
                2'h2: begin
                    if (bitn == `IMS_ACK_BIT) begin
                        if (state == `IMS_S_TX) begin
                            slave_nack <= sda_in;
                        end
                    end else if (state == `IMS_S_TX) begin
                        shift <= {shift[6:0], 1'b0};
                    end else begin
                        shift <= {shift[6:0], sda_in};
                    end
                end
                default: begin
                    scl_oe <= 1'b1;
                    if (bitn != `IMS_ACK_BIT) begin
                        bitn <= bitn + 1'b1;
                    end else if (state == `IMS_S_RX) begin
                        push_valid <= 1'b1; // ack held until next low phase
                        state      <= `IMS_S_PUSH;
                    end else begin
                        sda_oe      <= 1'b0;
                        event_flag  <= 1'b1;
                        status_seen <= 1'b0;
                        if (addr_10bit && !hdr_sent && is_header(addr_byte)
                            && !addr_byte[0]) begin
                            hdr_sent <= 1'b1;
                            state    <= `IMS_S_WHDR;
                        end else begin
                            state <= `IMS_S_WCTL;
                        end
                    end
                end
                endcase
            end
            `IMS_S_WCTL: begin
                scl_oe <= 1'b1;
                phase  <= 2'h0;
                bitn   <= 4'h0;
                if (control_write && status_seen) begin
                    event_flag  <= 1'b0;
                    status_seen <= 1'b0;
                    if (start_req) begin
                        state <= `IMS_S_START;
                    end else if (stop_req || !addr_byte[0]) begin
                        state <= `IMS_S_STOP;
                    end else begin
                        state <= `IMS_S_RX;
                    end
                end
            end
            `IMS_S_PUSH: begin
                scl_oe <= 1'b1;
                if (push_ready) begin
                    push_valid             <= 1'b0;
                    event_flag             <= 1'b1;
                    byte_transfer_finished <= 1'b1;
                    status_seen            <= 1'b0;
                    state                  <= `IMS_S_WRX;
                end
            end
            `IMS_S_WRX: begin
                scl_oe <= 1'b1;
                phase  <= 2'h0;
                bitn   <= 4'h0;
                if (fifo_pop) begin
                    event_flag             <= 1'b0;
                    byte_transfer_finished <= 1'b0;
                    status_seen            <= 1'b0;
                    stop_pend              <= 1'b0;
                    if (stop_req || stop_pend) begin
                        state <= `IMS_S_STOP;
                    end else begin
                        state <= `IMS_S_RX;
                    end
                end
            end
            `IMS_S_STOP: if (tick) begin
                phase <= phase + 1'b1;
                case (phase)
                2'h0: sda_oe <= 1'b1;
                2'h1: begin
                    if (scl_oe) begin
                        scl_oe <= 1'b0;
                        phase  <= phase;
                    end else if (!scl_in) begin
                        phase <= phase;
                    end
                end
                2'h2: sda_oe <= 1'b0;
                default: begin
                    master_select_flag <= 1'b0;
                    state              <= `IMS_S_IDLE;
                end
                endcase
            end
            default: state <= `IMS_S_IDLE;
            endcase
            // a new event in the clearing cycle keeps its flag
            if (state == `IMS_S_PUSH && push_ready) begin
                event_flag <= 1'b1;
            end
        end
    end
endmodule // ims_master

// >>> testbench/ims_master_assertions.sv
// concurrent checks on the master sequencer ports
`timescale 1ns/10ps
module ims_master_assertions #(
    parameter QTR = 3
) (
    input logic mclk,
    input logic rst_b,
    input logic peripheral_enable,
    input logic start_req,
    input logic bus_busy,
    input logic master_select_flag,
    input logic event_flag,
    input logic start_sent_flag,
    input logic byte_transfer_finished,
    input logic event_interrupt_enable,
    input logic event_irq,
    input logic status_read,
    input logic data_write,
    input logic data_read,
    input logic control_write,
    input logic data_valid,
    input logic scl_oe,
    input logic sda_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic sr_seen;
    // status read seen while the current event waits
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            sr_seen <= 1'b0;
        else if (!event_flag)
            sr_seen <= 1'b0;
        else if (status_read)
            sr_seen <= 1'b1;
    end
    // master mode only through an accepted start
    property p_enter;
        $rose(master_select_flag) |->
            $past(start_req & peripheral_enable & !bus_busy);
    endproperty
    a_enter: assert property (p_enter)
        else $error("master mode entered without start");
    // a busy bus keeps the block slave
    property p_busy;
        !master_select_flag && bus_busy |=> !master_select_flag;
    endproperty
    a_busy: assert property (p_busy)
        else $error("start taken on busy bus");
    // start drives sda low with scl released
    property p_start;
        $rose(master_select_flag) |-> ##[0:60] (sda_oe && !scl_oe);
    endproperty
    a_start: assert property (p_start)
        else $error("no start condition driven");
    // start-sent goes with the event flag
    property p_sb;
        $rose(start_sent_flag) |-> event_flag && master_select_flag;
    endproperty
    a_sb: assert property (p_sb)
        else $error("start-sent without event");
    // interrupt follows gated event one cycle late
    property p_irq;
        event_irq == $past(event_flag & event_interrupt_enable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("event interrupt wrong");
    // scl stretched while an event waits
    property p_hold;
        event_flag && $past(event_flag) |-> scl_oe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("scl not held during event");
    // event clears only after the second access
    property p_clear;
        $fell(event_flag) |-> $past(sr_seen
            && (data_write | data_read | control_write));
    endproperty
    a_clear: assert property (p_clear)
        else $error("event cleared without access pair");
    // byte-finished only with event and a byte ready
    property p_btf;
        $rose(byte_transfer_finished) |-> event_flag && data_valid;
    endproperty
    a_btf: assert property (p_btf)
        else $error("byte-finished without event or data");
    // leaving master releases both lines
    property p_release;
        $fell(master_select_flag) |-> ##[0:40] (!scl_oe && !sda_oe);
    endproperty
    a_release: assert property (p_release)
        else $error("lines not released after stop");
endmodule // ims_master_assertions

// >>> testbench/ims_slave_model.sv
// behavioural i2c slave answering the master sequencer
`timescale 1ns/10ps
module ims_slave_model (
    input  wire       scl,
    input  wire       sda,
    output reg        sda_pull,
    output reg  [7:0] got,
    output reg        mack
);
    reg [3:0] n;
    reg       act;
    reg       first;
    reg       rd;
    reg [7:0] tx;
    initial begin
        sda_pull = 1'b0;
        act = 1'b0;
        rd = 1'b0;
        tx = 8'hC3;
        mack = 1'b0;
    end
    // start or repeated start opens a new address byte
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        n = 0;
        first = 1'b1;
        rd = 1'b0;
    end
    // stop closes the frame
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    // sample bits, master ack ends or continues a read
    always @(posedge scl) if (act) begin
        if (n < 8)
            got = {got[6:0], sda};
        else if (rd && !first) begin
            mack = sda;
            rd = !sda;
            tx = tx + 8'h3B;
        end
        n = n + 1;
    end
    // ack writes, release for master ack, drive read bits msb first
    always @(negedge scl) if (act) begin
        if (n == 8) begin
            if (first) rd = got[0];
            sda_pull = first | !rd;
        end else if (n == 9) begin
            n = 0;
            first = 1'b0;
            sda_pull = rd & !tx[7];
        end else
            sda_pull = rd & !first & !tx[7-n];
    end
endmodule // ims_slave_model

// >>> testbench/ims_master_tb.sv
// testbench of the master sequencer against a slave model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module ims_master_tb;
    logic       mclk, rst_b, peripheral_enable, start_req, stop_req;
    logic       ack_en, addr_10bit, event_interrupt_enable;
    logic       status_read, data_write, data_read, control_write;
    logic [7:0] data_wdata, data_reg, got, exp_b, exp_d;
    logic       ext_sda;
    logic       data_valid, master_select_flag, event_flag, start_sent_flag;
    logic       byte_transfer_finished, bus_busy, slave_nack, event_irq;
    logic       scl_out, scl_oe, sda_out, sda_oe, sda_pull, mack;
    wire        scl_w = scl_oe ? scl_out : 1'b1;
    wire        sda_w = (sda_oe ? sda_out : 1'b1) & !sda_pull & !ext_sda;
    int         failures, num_checks, seed, t, i;
    logic [7:0] exp_q[$];
    ims_master #(.QTR(3)) ims_master_i (.mclk, .rst_b, .peripheral_enable,
        .start_req, .stop_req, .ack_en, .addr_10bit, .event_interrupt_enable,
        .status_read, .data_write, .data_wdata, .data_read, .control_write,
        .data_reg, .data_valid, .master_select_flag, .event_flag,
        .start_sent_flag, .byte_transfer_finished, .bus_busy, .slave_nack,
        .event_irq, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w),
        .sda_out, .sda_oe);
    ims_slave_model ims_slave_model_i (.scl(scl_w), .sda(sda_w),
        .sda_pull, .got, .mack);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = !mclk;
    end
    task tick;
        @(posedge mclk);
        #1;
    endtask
    // one software access: 0 status, 1 data write, 2 control, 3 data read
    task acc(input int w, input logic [7:0] d);
        data_wdata = d;
        case (w)
            0: status_read = 1'b1;
            1: data_write = 1'b1;
            2: control_write = 1'b1;
            default: data_read = 1'b1;
        endcase
        tick;
        {status_read, data_write, control_write, data_read} = 4'h0;
        tick;
    endtask
    task wait_evt(input string nm);
        i = 0;
        while (event_flag !== 1'b1 && i < 3000) begin
            tick;
            i++;
        end
        if (i == 3000) begin
            failures++;
            $display("unexpected %s exp event got none", nm);
        end
    endtask
    // one master read: start, address, n bytes, stop
    task run_read(input logic ten);
        logic [9:0] a;
        logic [7:0] hdr;
        int n, k;
        a = $random(seed);
        n = 2 + ($random(seed) & 3);
        event_interrupt_enable = $random(seed);
        ack_en = 1'b1;
        addr_10bit = ten;
        hdr = ten ? {5'h1E, a[9:8], 1'b0} : {a[6:0], 1'b1};
        start_req = 1'b1;
        wait_evt("start");
        `CHK("master", 1'b1, master_select_flag)
        `CHK("sb", 1'b1, start_sent_flag)
        repeat (20) tick;
        `CHK("irq", event_interrupt_enable, event_irq)
        `CHK("hold_start", 1'b1, scl_oe)
        start_req = 1'b0;
        acc(0, 8'h00);
        acc(1, hdr);
        wait_evt("addr");
        `CHK("hdr", hdr, got)
        if (ten) begin
            acc(0, 8'h00);
            acc(1, a[7:0]);
            wait_evt("addr2");
            `CHK("lo", a[7:0], got)
            start_req = 1'b1;
            acc(0, 8'h00);
            acc(2, 8'h00);
            wait_evt("rstart");
            start_req = 1'b0;
            hdr[0] = 1'b1;
            acc(0, 8'h00);
            acc(1, hdr);
            wait_evt("addr3");
            `CHK("rd_hdr", hdr, got)
        end
        `CHK("nack", 1'b0, slave_nack)
        `CHK("hold_ctl", 1'b1, scl_oe)
        for (k = 0; k < n; k++) begin
            exp_q.push_back(exp_b);
            exp_b = exp_b + 8'h3B;
        end
        acc(0, 8'h00);
        acc(2, 8'h00);
        for (k = 0; k < n; k++) begin
            wait_evt("byte");
            `CHK("btf", 1'b1, byte_transfer_finished)
            `CHK("mack", k == n - 1, mack)
            repeat (5) tick;
            `CHK("hold_rx", 1'b1, scl_oe)
            `CHK("valid", 1'b1, data_valid)
            if (k == n - 2) ack_en = 1'b0;
            if (k == n - 1) begin
                stop_req = 1'b1;
                if (t[1]) begin
                    tick;
                    stop_req = 1'b0;
                end
            end
            acc(0, 8'h00);
            exp_d = exp_q.pop_front();
            `CHK("data", exp_d, data_reg)
            acc(3, 8'h00);
        end
        i = 0;
        while (master_select_flag !== 1'b0 && i < 500) begin
            tick;
            i++;
        end
        stop_req = 1'b0;
        repeat (30) tick;
        `CHK("slave_again", 1'b0, master_select_flag)
        `CHK("bus_free", 1'b0, bus_busy)
        $display("read of %0d bytes done, ten bit %0d", n, ten);
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst_b, peripheral_enable, start_req, stop_req, ack_en} = 5'h00;
        {addr_10bit, event_interrupt_enable, status_read} = 3'h0;
        {data_write, data_read, control_write} = 3'h0;
        data_wdata = 8'h00;
        ext_sda = 1'b0;
        exp_b = 8'hC3;
        seed = 32'h2f67;
        repeat (5) @(posedge mclk);
        #1 rst_b = 1'b1;
        `CHK("reset_slave", 1'b0, master_select_flag)
        start_req = 1'b1;
        repeat (30) tick;
        `CHK("refused", 1'b0, master_select_flag)
        // another master holds the bus: start must be refused
        ext_sda = 1'b1;
        tick;
        peripheral_enable = 1'b1;
        repeat (30) tick;
        `CHK("busy", 1'b1, bus_busy)
        `CHK("busy_refused", 1'b0, master_select_flag)
        {start_req, ext_sda} = 2'h0;
        repeat (5) tick;
        `CHK("bus_idle", 1'b0, bus_busy)
        for (t = 0; t < 4; t++) run_read(t[0]);
        give_verdict;
    end
    initial begin
        #(40 * 60000);
        failures++;
        give_verdict;
    end
endmodule // ims_master_tb
bind ims_master ims_master_assertions #(.QTR(QTR)) ims_master_chk (.mclk,
    .rst_b, .peripheral_enable, .start_req, .bus_busy, .master_select_flag,
    .event_flag, .start_sent_flag, .byte_transfer_finished,
    .event_interrupt_enable, .event_irq, .status_read, .data_write,
    .data_read, .control_write, .data_valid, .scl_oe, .sda_oe);
